// ---- rtl/tbcp_pkg.sv ----
// Constants, field layout and helpers shared by both ends of the transmit buffer link
package tbcp_pkg;
  localparam int DW_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int POS_W = 12;
  localparam int CNT_W = 11;
  localparam int OFF_W = 5;
  localparam int TAG_W = 16;
  localparam int BYTE_W = 8;
  localparam int A_IOC_BIT = 31;
  localparam int A_ALIGN_LSB = 24;
  localparam int A_OFF_LSB = 16;
  localparam int A_FS_BIT = 13;
  localparam int A_LS_BIT = 12;
  localparam int SIZE_LSB = 0;
  localparam int B_TAG_LSB = 16;
  localparam int B_CRC_DIS_BIT = 13;
  localparam int B_PAD_DIS_BIT = 12;
  localparam logic [6:0] MAX_BUFS = 7'h56;
  localparam logic [POS_W-1:0] DW_BYTES = 12'h004;
  localparam logic [POS_W-1:0] POS_ONE = 12'h001;
  localparam logic [POS_W-1:0] MASK_4 = 12'h003;
  localparam logic [POS_W-1:0] MASK_16 = 12'h00f;
  localparam logic [POS_W-1:0] MASK_32 = 12'h01f;
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] LANE_LAST = 2'h3;

  // Reserved alignment code falls back to 4-byte
  function automatic logic [POS_W-1:0] tbcp_round_up(input logic [POS_W-1:0] end_b, input logic [1:0] algn);
    logic [POS_W-1:0] m;
    m = MASK_4;
    case (algn)
      ALIGN_16: m = MASK_16;
      ALIGN_32: m = MASK_32;
      default: m = MASK_4;
    endcase
    return (end_b + m) & ~m;
  endfunction : tbcp_round_up

  function automatic logic [POS_W-1:0] tbcp_start(input logic [OFF_W-1:0] off);
    return {{(POS_W-OFF_W){1'b0}}, off};
  endfunction : tbcp_start
endpackage : tbcp_pkg

// ---- rtl/tbcp_if.sv ----
// DWORD write channel between the host processor end and the device end
`timescale 1ns/100ps
`default_nettype none
interface tbcp_if;
  logic dw_valid;
  logic [tbcp_pkg::DW_W-1:0] dw_data;
  logic dw_ready;
  modport host_mp (output dw_valid, output dw_data, input dw_ready);
  modport dev_mp (input dw_valid, input dw_data, output dw_ready);
endinterface : tbcp_if
`default_nettype wire

// ---- rtl/tbcp_fifo.sv ----
// Parameterised synchronous FIFO with registered flags
`timescale 1ns/100ps
`default_nettype none
module tbcp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Sync reset, active low
  input wire logic in_valid, // Write request
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic in_ready, // Room available
  output logic out_valid, // Word available
  output logic [WIDTH-1:0] out_data, // Head word
  input wire logic out_ready // Consumer takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic in_ready_ff, out_valid_ff;
  logic do_wr, do_rd;

  always_comb begin
    do_wr = in_valid && in_ready_ff;
    do_rd = out_ready && out_valid_ff;
    nxt_wr = do_wr ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = do_rd ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      in_ready_ff <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      in_ready_ff <= nxt_cnt != (AW+1)'(DEPTH);
      out_valid_ff <= nxt_cnt != '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = mem_ff[rd_ff];
endmodule : tbcp_fifo
`default_nettype wire

// ---- rtl/tbcp_dev.sv ----
// Device end: parses buffer commands and forwards payload bytes to the MAC transmit FIFO
`timescale 1ns/100ps
`default_nettype none
module tbcp_dev (
  input wire logic mclk, // Clock, 200 MHz
  input wire logic rst_b, // Sync reset, active low
  tbcp_if.dev_mp link, // DWORD stream from host
  output logic [tbcp_pkg::BYTE_W-1:0] mac_byte, // Payload byte to mac_transmit_fifo
  output logic mac_valid, // Payload byte valid
  output logic mac_last, // Final byte of packet
  input wire logic mac_ready, // mac_transmit_fifo accepts byte
  output logic pkt_start, // Pulse: new packet controls valid
  output logic [tbcp_pkg::TAG_W-1:0] pkt_tag, // Tag for the status word
  output logic pkt_add_crc, // Append CRC to this packet
  output logic pkt_add_pad, // Pad short frames of this packet
  output logic transmit_error_flag, // Pulse: length mismatch at packet end
  output logic buffer_done_flag // Pulse: buffer fully loaded
);
  typedef enum logic [1:0] {S_CMDA, S_CMDB, S_LOAD, S_BYTE} tbcp_dst_e;

  logic fq_valid, fq_take;
  logic [tbcp_pkg::DW_W-1:0] fq_data;

  // Input queue decouples host writes from byte-wide draining
  tbcp_fifo #(.WIDTH(tbcp_pkg::DW_W), .DEPTH(tbcp_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(link.dw_valid),
    .in_data(link.dw_data),
    .in_ready(link.dw_ready),
    .out_valid(fq_valid),
    .out_data(fq_data),
    .out_ready(fq_take)
  );

  tbcp_dst_e st_ff, nxt_st;
  logic [tbcp_pkg::POS_W-1:0] pos_ff, nxt_pos, start_ff, nxt_start, end_ff, nxt_end, rnd_ff, nxt_rnd;
  logic [tbcp_pkg::POS_W-1:0] sum_ff, nxt_sum, len_ff, nxt_len;
  logic [tbcp_pkg::DW_W-1:0] word_ff, nxt_word;
  logic ioc_ff, nxt_ioc, ls_ff, nxt_ls;
  // First segment is remembered so command B of later buffers leaves packet controls alone
  logic fs_ff, nxt_fs;
  logic [tbcp_pkg::BYTE_W-1:0] byte_ff, nxt_byte;
  logic mval_ff, nxt_mval, mlast_ff, nxt_mlast, pstart_ff, nxt_pstart;
  logic [tbcp_pkg::TAG_W-1:0] tag_ff, nxt_tag;
  logic crc_ff, nxt_crc, pad_ff, nxt_pad, err_ff, nxt_err, done_ff, nxt_done;
  logic [tbcp_pkg::CNT_W-1:0] a_size;
  logic [tbcp_pkg::OFF_W-1:0] a_off;
  logic [1:0] a_algn;
  logic [tbcp_pkg::POS_W-1:0] a_end, pos_adv;
  logic in_rng, slot_free;

  always_comb begin
    a_size = fq_data[tbcp_pkg::SIZE_LSB +: tbcp_pkg::CNT_W];
    a_off = fq_data[tbcp_pkg::A_OFF_LSB +: tbcp_pkg::OFF_W];
    a_algn = fq_data[tbcp_pkg::A_ALIGN_LSB +: 2];
    // Buffer end in byte positions counted from the first data DWORD
    a_end = tbcp_pkg::tbcp_start(a_off) + {1'b0, a_size};
    in_rng = (pos_ff >= start_ff) && (pos_ff < end_ff);
    slot_free = !mval_ff || mac_ready;
    pos_adv = pos_ff + tbcp_pkg::POS_ONE;
    nxt_st = st_ff;
    nxt_pos = pos_ff;
    nxt_start = start_ff;
    nxt_end = end_ff;
    nxt_rnd = rnd_ff;
    nxt_sum = sum_ff;
    nxt_len = len_ff;
    nxt_word = word_ff;
    nxt_ioc = ioc_ff;
    nxt_ls = ls_ff;
    nxt_fs = fs_ff;
    nxt_byte = byte_ff;
    nxt_mval = mval_ff && !mac_ready;
    nxt_mlast = mlast_ff;
    nxt_pstart = 1'b0;
    nxt_tag = tag_ff;
    nxt_crc = crc_ff;
    nxt_pad = pad_ff;
    nxt_err = 1'b0;
    nxt_done = 1'b0;
    fq_take = 1'b0;
    case (st_ff)
      S_CMDA: begin
        if (fq_valid) begin
          fq_take = 1'b1;
          nxt_start = tbcp_pkg::tbcp_start(a_off);
          nxt_end = a_end;
          nxt_rnd = tbcp_pkg::tbcp_round_up(a_end, a_algn);
          nxt_ioc = fq_data[tbcp_pkg::A_IOC_BIT];
          nxt_ls = fq_data[tbcp_pkg::A_LS_BIT];
          nxt_fs = fq_data[tbcp_pkg::A_FS_BIT];
          if (fq_data[tbcp_pkg::A_FS_BIT]) begin
            nxt_sum = {1'b0, a_size};
          end else begin
            // A middle or last buffer adds to the running count of the open packet
            nxt_sum = sum_ff + {1'b0, a_size};
          end
          nxt_st = S_CMDB;
        end
      end
      S_CMDB: begin
        if (fq_valid) begin
          fq_take = 1'b1;
          nxt_pos = '0;
          nxt_st = S_LOAD;
          // Command B is parsed on every buffer; packet controls latch on the first one
          if (fs_ff) begin
            nxt_len = {1'b0, fq_data[tbcp_pkg::SIZE_LSB +: tbcp_pkg::CNT_W]};
            nxt_pstart = 1'b1;
            nxt_tag = fq_data[tbcp_pkg::B_TAG_LSB +: tbcp_pkg::TAG_W];
            nxt_pad = !fq_data[tbcp_pkg::B_PAD_DIS_BIT];
            nxt_crc = !fq_data[tbcp_pkg::B_CRC_DIS_BIT] || fq_data[tbcp_pkg::B_PAD_DIS_BIT];
          end
        end
      end
      S_LOAD: begin
        if (pos_ff == rnd_ff) begin
          nxt_done = ioc_ff;
          nxt_err = ls_ff && (sum_ff != len_ff);
          nxt_st = S_CMDA;
        end else if (fq_valid) begin
          fq_take = 1'b1;
          // Whole DWORDs of offset or end padding are dropped unopened
          if ((pos_ff + tbcp_pkg::DW_BYTES <= start_ff) || (pos_ff >= end_ff)) begin
            nxt_pos = pos_ff + tbcp_pkg::DW_BYTES;
          end else begin
            nxt_word = fq_data;
            nxt_st = S_BYTE;
          end
        end
      end
      S_BYTE: begin
        // Lanes outside the payload cost one cycle each but never reach the MAC side
        if (!in_rng || slot_free) begin
          nxt_pos = pos_adv;
          if (pos_ff[1:0] == tbcp_pkg::LANE_LAST) begin
            nxt_st = S_LOAD;
          end
        end
        if (in_rng && slot_free) begin
          nxt_byte = word_ff[pos_ff[1:0]*tbcp_pkg::BYTE_W +: tbcp_pkg::BYTE_W];
          nxt_mval = 1'b1;
          nxt_mlast = ls_ff && (pos_adv == end_ff);
        end
      end
      default: nxt_st = S_CMDA;
    endcase
  end

  // Packet controls reset to the safe default of CRC and padding on
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff <= S_CMDA;
      pos_ff <= '0;
      start_ff <= '0;
      end_ff <= '0;
      rnd_ff <= '0;
      sum_ff <= '0;
      len_ff <= '0;
      word_ff <= '0;
      ioc_ff <= 1'b0;
      ls_ff <= 1'b0;
      fs_ff <= 1'b0;
      byte_ff <= '0;
      mval_ff <= 1'b0;
      mlast_ff <= 1'b0;
      pstart_ff <= 1'b0;
      tag_ff <= '0;
      crc_ff <= 1'b1;
      pad_ff <= 1'b1;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      pos_ff <= nxt_pos;
      start_ff <= nxt_start;
      end_ff <= nxt_end;
      rnd_ff <= nxt_rnd;
      sum_ff <= nxt_sum;
      len_ff <= nxt_len;
      word_ff <= nxt_word;
      ioc_ff <= nxt_ioc;
      ls_ff <= nxt_ls;
      fs_ff <= nxt_fs;
      byte_ff <= nxt_byte;
      mval_ff <= nxt_mval;
      mlast_ff <= nxt_mlast;
      pstart_ff <= nxt_pstart;
      tag_ff <= nxt_tag;
      crc_ff <= nxt_crc;
      pad_ff <= nxt_pad;
      err_ff <= nxt_err;
      done_ff <= nxt_done;
    end
  end

  assign mac_byte = byte_ff;
  assign mac_valid = mval_ff;
  assign mac_last = mlast_ff;
  assign pkt_start = pstart_ff;
  assign pkt_tag = tag_ff;
  assign pkt_add_crc = crc_ff;
  assign pkt_add_pad = pad_ff;
  assign transmit_error_flag = err_ff;
  assign buffer_done_flag = done_ff;
endmodule : tbcp_dev
`default_nettype wire

// ---- rtl/tbcp_host.sv ----
// Host end: builds command words and aligned, padded data DWORDs for one buffer at a time
`timescale 1ns/100ps
`default_nettype none
module tbcp_host (
  input wire logic mclk, // Clock, 200 MHz
  input wire logic rst_b, // Sync reset, active low
  tbcp_if.host_mp link, // DWORD stream to device
  input wire logic store_forward_select, // Enforce buffer count cap
  input wire logic req_valid, // Buffer request
  output logic req_ready, // Request may be taken
  input wire logic [tbcp_pkg::CNT_W-1:0] req_size, // Payload bytes in buffer
  input wire logic [tbcp_pkg::OFF_W-1:0] req_off, // Data start offset
  input wire logic [1:0] req_align, // End alignment code
  input wire logic req_first, // first_segment_marker
  input wire logic req_last, // last_segment_marker
  input wire logic req_done_irq, // Ask for buffer_done_flag
  input wire logic [tbcp_pkg::TAG_W-1:0] req_tag, // Packet tag
  input wire logic [tbcp_pkg::CNT_W-1:0] req_len, // Packet length
  input wire logic req_crc_dis, // Disable CRC append
  input wire logic req_pad_dis, // Disable frame padding
  input wire logic [tbcp_pkg::BYTE_W-1:0] usr_byte, // Payload byte
  input wire logic usr_valid, // Payload byte valid
  output logic usr_ready, // Payload byte taken
  output logic req_refused // Pulse: request dropped
);
  typedef enum logic [2:0] {H_IDLE, H_CA, H_CB, H_BYTE, H_SEND} tbcp_hst_e;

  tbcp_hst_e st_ff, nxt_st;
  logic [tbcp_pkg::POS_W-1:0] pos_ff, nxt_pos, start_ff, nxt_start, end_ff, nxt_end, rnd_ff, nxt_rnd;
  logic [tbcp_pkg::DW_W-1:0] word_ff, nxt_word, dat_ff, nxt_dat, cmdb_ff, nxt_cmdb;
  logic val_ff, nxt_val, rdy_ff, nxt_rdy, urdy_ff, nxt_urdy, ref_ff, nxt_ref;
  logic [6:0] bufs_ff, nxt_bufs;
  logic [tbcp_pkg::POS_W-1:0] r_end;
  logic [tbcp_pkg::BYTE_W-1:0] lane_byte;
  logic in_rng, bad, step;

  always_comb begin
    r_end = tbcp_pkg::tbcp_start(req_off) + {1'b0, req_size};
    bad = (!req_first && !req_last && req_size < tbcp_pkg::CNT_W'(tbcp_pkg::DW_BYTES))
      || (store_forward_select && !req_first && bufs_ff >= tbcp_pkg::MAX_BUFS);
    in_rng = (pos_ff >= start_ff) && (pos_ff < end_ff);
    step = !in_rng || (usr_valid && urdy_ff);
    lane_byte = in_rng ? usr_byte : '0;
    nxt_st = st_ff;
    nxt_pos = pos_ff;
    nxt_start = start_ff;
    nxt_end = end_ff;
    nxt_rnd = rnd_ff;
    nxt_word = word_ff;
    nxt_dat = dat_ff;
    nxt_cmdb = cmdb_ff;
    nxt_val = val_ff;
    nxt_bufs = bufs_ff;
    nxt_ref = 1'b0;
    case (st_ff)
      H_IDLE: begin
        if (req_valid && rdy_ff) begin
          if (bad) begin
            nxt_ref = 1'b1;
          end else begin
            nxt_bufs = req_first ? 7'h01 : bufs_ff + 7'h01;
            nxt_start = tbcp_pkg::tbcp_start(req_off);
            nxt_end = r_end;
            nxt_rnd = tbcp_pkg::tbcp_round_up(r_end, req_align);
            nxt_dat = '0;
            nxt_dat[tbcp_pkg::A_IOC_BIT] = req_done_irq;
            nxt_dat[tbcp_pkg::A_ALIGN_LSB +: 2] = req_align;
            nxt_dat[tbcp_pkg::A_OFF_LSB +: tbcp_pkg::OFF_W] = req_off;
            nxt_dat[tbcp_pkg::A_FS_BIT] = req_first;
            nxt_dat[tbcp_pkg::A_LS_BIT] = req_last;
            nxt_dat[tbcp_pkg::SIZE_LSB +: tbcp_pkg::CNT_W] = req_size;
            nxt_cmdb = '0;
            nxt_cmdb[tbcp_pkg::B_TAG_LSB +: tbcp_pkg::TAG_W] = req_tag;
            nxt_cmdb[tbcp_pkg::B_CRC_DIS_BIT] = req_crc_dis;
            nxt_cmdb[tbcp_pkg::B_PAD_DIS_BIT] = req_pad_dis;
            nxt_cmdb[tbcp_pkg::SIZE_LSB +: tbcp_pkg::CNT_W] = req_len;
            nxt_val = 1'b1;
            nxt_st = H_CA;
          end
        end
      end
      H_CA: begin
        if (link.dw_ready) begin
          nxt_dat = cmdb_ff;
          nxt_st = H_CB;
        end
      end
      H_CB, H_SEND: begin
        if (link.dw_ready) begin
          nxt_val = 1'b0;
          nxt_pos = (st_ff == H_CB) ? '0 : pos_ff;
          nxt_st = (nxt_pos == rnd_ff) ? H_IDLE : H_BYTE;
        end
      end
      H_BYTE: begin
        if (step) begin
          nxt_word[pos_ff[1:0]*tbcp_pkg::BYTE_W +: tbcp_pkg::BYTE_W] = lane_byte;
          nxt_pos = pos_ff + tbcp_pkg::POS_ONE;
          if (pos_ff[1:0] == tbcp_pkg::LANE_LAST) begin
            nxt_dat = nxt_word;
            nxt_val = 1'b1;
            nxt_st = H_SEND;
          end
        end
      end
      default: nxt_st = H_IDLE;
    endcase
    nxt_rdy = (nxt_st == H_IDLE);
    nxt_urdy = (nxt_st == H_BYTE) && (nxt_pos >= nxt_start) && (nxt_pos < nxt_end);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff <= H_IDLE;
      pos_ff <= '0;
      start_ff <= '0;
      end_ff <= '0;
      rnd_ff <= '0;
      word_ff <= '0;
      dat_ff <= '0;
      cmdb_ff <= '0;
      val_ff <= 1'b0;
      rdy_ff <= 1'b0;
      urdy_ff <= 1'b0;
      ref_ff <= 1'b0;
      bufs_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      pos_ff <= nxt_pos;
      start_ff <= nxt_start;
      end_ff <= nxt_end;
      rnd_ff <= nxt_rnd;
      word_ff <= nxt_word;
      dat_ff <= nxt_dat;
      cmdb_ff <= nxt_cmdb;
      val_ff <= nxt_val;
      rdy_ff <= nxt_rdy;
      urdy_ff <= nxt_urdy;
      ref_ff <= nxt_ref;
      bufs_ff <= nxt_bufs;
    end
  end

  assign link.dw_valid = val_ff;
  assign link.dw_data = dat_ff;
  assign req_ready = rdy_ff;
  assign usr_ready = urdy_ff;
  assign req_refused = ref_ff;
endmodule : tbcp_host
`default_nettype wire

// ---- verif/tbcp_checker.sv ----
// Checker for the DWORD link between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
module tbcp_checker (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Sync reset, active low
  input wire logic dw_valid, // Word offered
  input wire logic [tbcp_pkg::DW_W-1:0] dw_data, // Word
  input wire logic dw_ready // Device room
);
  logic [1:0] ph_ff, nxt_ph;
  logic [4:0] off_ff, nxt_off;
  logic [11:0] end_ff, nxt_end, e, m;
  logic [9:0] nw_ff, nxt_nw, wi_ff, nxt_wi;
  wire take = dw_valid && dw_ready;
  wire in_a = dw_valid && ph_ff == 2'h0;
  wire in_b = dw_valid && ph_ff == 2'h1;
  wire in_d = dw_valid && ph_ff == 2'h2;
  wire [9:0] pend = 10'((end_ff + 12'h003) >> 2);
  wire [31:0] lowm = ~(32'hffff_ffff << {off_ff[1:0], 3'h0});
  wire [9:0] skip = {7'h0, off_ff[4:2]};

  // Tracks where each link word sits inside its buffer
  always_comb begin
    nxt_ph = ph_ff;
    nxt_off = off_ff;
    nxt_end = end_ff;
    nxt_nw = nw_ff;
    nxt_wi = wi_ff;
    e = {7'h0, dw_data[20:16]} + {1'b0, dw_data[10:0]};
    m = dw_data[25] ? 12'h01f : (dw_data[24] ? 12'h00f : 12'h003);
    if (take) begin
      case (ph_ff)
        2'h0: begin
          nxt_ph = 2'h1;
          nxt_off = dw_data[20:16];
          nxt_end = e;
          nxt_nw = 10'(((e + m) & ~m) >> 2);
        end
        2'h1: begin
          nxt_ph = (nw_ff == 10'h000) ? 2'h0 : 2'h2;
          nxt_wi = 10'h000;
        end
        default: begin
          nxt_wi = wi_ff + 10'h001;
          if (wi_ff + 10'h001 == nw_ff) nxt_ph = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    ph_ff <= rst_b ? nxt_ph : 2'h0;
    off_ff <= nxt_off;
    end_ff <= nxt_end;
    nw_ff <= nxt_nw;
    wi_ff <= nxt_wi;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_hold; dw_valid && !dw_ready |=> dw_valid && $stable(dw_data); endproperty
  a_hold: assert property (p_hold) else $error("link word changed while stalled");
  property p_rsv_a; in_a |-> (dw_data & 32'h7ce0_c800) == 32'h0000_0000; endproperty
  a_rsv_a: assert property (p_rsv_a) else $error("first command word has reserved bits set");
  property p_rsv_b; in_b |-> (dw_data & 32'h0000_c800) == 32'h0000_0000; endproperty
  a_rsv_b: assert property (p_rsv_b) else $error("second command word has reserved bits set");
  property p_align; in_a |-> dw_data[25:24] != 2'h3; endproperty
  a_align: assert property (p_align) else $error("reserved alignment code sent");
  property p_middle; in_a && !dw_data[13] && !dw_data[12] |-> dw_data[10:0] >= 11'h004; endproperty
  a_middle: assert property (p_middle) else $error("middle buffer shorter than four bytes");
  property p_skip; in_d && wi_ff < skip |-> dw_data == 32'h0000_0000; endproperty
  a_skip: assert property (p_skip) else $error("skipped leading word not blank");
  property p_lane; in_d && wi_ff == skip |-> (dw_data & lowm) == 32'h0000_0000; endproperty
  a_lane: assert property (p_lane) else $error("lanes before first byte not blank");
  property p_pad; in_d && wi_ff >= pend |-> dw_data == 32'h0000_0000; endproperty
  a_pad: assert property (p_pad) else $error("alignment pad word not blank");
  property p_rel; $rose(rst_b) |-> !dw_ready ##1 dw_ready; endproperty
  a_rel: assert property (p_rel) else $error("link room wrong after reset release");
  // The bench never stalls the byte side long enough to starve this
  property p_progress; dw_valid && !dw_ready |-> ##[1:200] dw_ready; endproperty
  a_progress: assert property (p_progress) else $error("device stopped draining link");

  c_full: cover property (dw_valid && !dw_ready);
  c_single: cover property (in_a && dw_data[13] && dw_data[12]);
  c_align32: cover property (in_a && dw_data[25:24] == 2'h2);
endmodule : tbcp_checker
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench: host end and device end joined over the DWORD link
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk, rst_b, store_forward_select, req_valid, req_first, req_last, req_done_irq, req_crc_dis;
  logic req_pad_dis, usr_valid, mac_ready, req_ready, usr_ready, req_refused, mac_valid, mac_last;
  logic pkt_start, pkt_add_crc, pkt_add_pad, transmit_error_flag, buffer_done_flag, hold, stall, saw_full;
  logic [10:0] req_size, req_len;
  logic [4:0] req_off;
  logic [1:0] req_align;
  logic [15:0] req_tag, pkt_tag;
  logic [7:0] usr_byte, mac_byte, seed;
  logic [8:0] exp_q[$];
  int err_total, comparisons, cyc, n_done, n_terr, n_start, x_done, x_terr, x_start;

  tbcp_if link_if();
  tbcp_host tbcp_host_inst (.mclk, .rst_b, .link(link_if.host_mp), .store_forward_select, .req_valid, .req_ready,
    .req_size, .req_off, .req_align, .req_first, .req_last, .req_done_irq, .req_tag, .req_len, .req_crc_dis,
    .req_pad_dis, .usr_byte, .usr_valid, .usr_ready, .req_refused);
  tbcp_dev tbcp_dev_inst (.mclk, .rst_b, .link(link_if.dev_mp), .mac_byte, .mac_valid, .mac_last, .mac_ready,
    .pkt_start, .pkt_tag, .pkt_add_crc, .pkt_add_pad, .transmit_error_flag, .buffer_done_flag);
  tbcp_checker tbcp_checker_inst (.mclk, .rst_b, .dw_valid(link_if.dw_valid), .dw_data(link_if.dw_data),
    .dw_ready(link_if.dw_ready));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Byte side stalls while hold is set, so the link sees back-pressure, and on a fixed pattern while stall is set
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    mac_ready <= !(hold || (stall && cyc[2]));
    if (link_if.dw_valid && !link_if.dw_ready) saw_full <= 1'b1;
    if (buffer_done_flag === 1'b1) n_done <= n_done + 1;
    if (transmit_error_flag === 1'b1) n_terr <= n_terr + 1;
    if (pkt_start === 1'b1) n_start <= n_start + 1;
    if (mac_valid === 1'b1 && mac_ready === 1'b1) begin
      if (exp_q.size() == 0) check("mac_extra", 1, 0);
      else check("mac_byte", {mac_last, mac_byte}, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    check("crc_reset", pkt_add_crc, 1);
    check("pad_reset", pkt_add_pad, 1);
  endtask : do_reset

  task automatic send(input int size, input int off, input int al, input logic fs, input logic ls,
                      input logic irq, input int len, input logic crc_d, input logic pad_d, input logic refuse);
    int i;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_size <= 11'(size);
    req_off <= 5'(off);
    req_align <= 2'(al);
    req_first <= fs;
    req_last <= ls;
    req_done_irq <= irq;
    req_len <= 11'(len);
    req_tag <= 16'ha5c3 ^ 16'(len);
    req_crc_dis <= crc_d;
    req_pad_dis <= pad_d;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    if (refuse) begin
      @(posedge mclk);
      check("req_refused", req_refused, 1);
      return;
    end
    for (i = 0; i < size; i++) begin
      usr_byte <= seed;
      usr_valid <= 1'b1;
      exp_q.push_back({ls && i == size - 1, seed});
      seed = seed + 8'h01;
      do @(posedge mclk); while (usr_ready !== 1'b1);
    end
    usr_valid <= 1'b0;
  endtask : send

  // Flags land a few cycles after the last word, so a short quiet spell follows the drain
  task automatic settle(input int dd, input int dt, input int ds);
    int k;
    for (k = 0; k < 800 && exp_q.size() != 0; k++) @(posedge mclk);
    repeat (20) @(posedge mclk);
    x_done += dd;
    x_terr += dt;
    x_start += ds;
    check("bytes_left", exp_q.size(), 0);
    check("done_pulses", n_done, x_done);
    check("err_pulses", n_terr, x_terr);
    check("pkt_starts", n_start, x_start);
  endtask : settle

  task automatic t_single();
    send(7, 6, 1, 1, 1, 1, 7, 1, 0, 0);
    settle(1, 0, 1);
    check("pkt_tag", pkt_tag, 16'ha5c3 ^ 16'h0007);
    check("add_crc", pkt_add_crc, 0);
    check("add_pad", pkt_add_pad, 1);
  endtask : t_single

  task automatic t_multi();
    hold <= 1'b1;
    fork
      begin
        send(79, 7, 1, 1, 0, 1, 111, 1, 1, 0);
        send(15, 0, 1, 0, 0, 0, 111, 0, 0, 0);
        send(17, 10, 1, 0, 1, 1, 111, 0, 0, 0);
      end
      begin
        repeat (150) @(posedge mclk);
        hold <= 1'b0;
      end
    join
    settle(2, 0, 1);
    check("fifo_full_seen", saw_full, 1);
    check("pkt_tag", pkt_tag, 16'ha5c3 ^ 16'h006f);
    check("add_crc", pkt_add_crc, 1);
    check("add_pad", pkt_add_pad, 0);
  endtask : t_multi

  task automatic t_align();
    stall <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      send(5, 8 * a + 3, a, 1, 1, 0, 5, 0, 0, 0);
      settle(0, 0, 1);
    end
    stall <= 1'b0;
  endtask : t_align

  task automatic t_err();
    send(9, 2, 0, 1, 1, 0, 10, 0, 0, 0);
    settle(0, 1, 1);
    send(6, 0, 0, 1, 0, 0, 6, 0, 1, 0);
    send(0, 1, 0, 0, 1, 1, 6, 0, 0, 0);
    settle(1, 0, 1);
    send(3, 0, 0, 0, 0, 0, 3, 0, 0, 1);
  endtask : t_err

  task automatic t_cap();
    store_forward_select <= 1'b1;
    send(4, 1, 0, 1, 0, 0, 400, 0, 0, 0);
    repeat (85) send(4, 2, 0, 0, 0, 0, 400, 0, 0, 0);
    send(4, 0, 0, 0, 0, 0, 400, 0, 0, 1);
    store_forward_select <= 1'b0;
    settle(0, 0, 1);
  endtask : t_cap

  initial begin
    rst_b = 1'b0;
    store_forward_select = 1'b0;
    req_valid = 1'b0;
    {req_first, req_last, req_done_irq, req_crc_dis, req_pad_dis, usr_valid} = 6'h00;
    {req_size, req_len, req_off, req_align, req_tag, usr_byte} = 53'h0;
    {mac_ready, hold, stall, saw_full} = 4'h8;
    seed = 8'h11;
    {cyc, err_total, comparisons, n_done, n_terr, n_start, x_done, x_terr, x_start} = '0;
    do_reset();
    t_single();
    t_multi();
    t_align();
    t_err();
    do_reset();
    t_cap();
    final_report();
  end
endmodule : testbench
`default_nettype wire
